// File: rtl/pmc_defines.svh
// constants for the power mode controller
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_ADDR_CTRL 4'h0
`define PMC_ADDR_STATUS 4'h1
`define PMC_ADDR_THRESH 4'h2
`define PMC_ADDR_BATT 4'h3
`define PMC_CTRL_SHIP 0
`define PMC_CTRL_AUX 1
`define PMC_THRESH_RST 12'hC00
`define PMC_THRESH_MAX 12'hD00
`define PMC_HYST_MV 12'h096
`define PMC_WAKE_MS 32'd1000
`define PMC_CLK_MHZ 32'd250
`define PMC_UNMAPPED 32'hFFFFFFFF
`endif

// File: rtl/pmc_pkg.sv
// types for the power mode controller
package pmc_pkg;
   typedef enum logic [1:0] {
      PMC_SHIP,
      PMC_CHARGE,
      PMC_ACTIVE,
      PMC_LOWPWR
   } pmc_mode_t;
endpackage

// File: rtl/pmc_power_mode_controller.sv
// mode controller: ship, charge/adapter, active battery, low power
//
// Notes on behaviour
// - exactly four modes: ship, low power, active battery, charge/adapter
// - interrupt, serial, ADC only in charge or active; charge enable in charge
// - ship latches off; exit by input valid or held-then-released button
// - ship entry ignores the charge-enable input
// - battery insertion with no valid input and button high goes straight to ship
// - ship request with valid input waits until input removed
// - ship request with button low waits until button high
// - button exit from ship needs battery above highest threshold
// - host may clear ship request while input valid; entry cancelled
// - watchdog expiry keeps ship request; pending entry still completes
// - in ship only input comparator and button remain active
// - low power needs select low, input low, button high, serial idle
// - low power disables serial, ADC and oscillators; button stays on
// - aux output keeps its enable state into low power
// - low power left on select high or input valid
// - overvoltage input with select low gives active battery mode
// - select low with button held gives active battery mode
// - button released with select low returns to low power
// - outside ship, no input, battery ok: discharge switch on
// - switch off on overcurrent or battery undervoltage
// - battery threshold programmable with fixed 150 mV hysteresis
// - input valid gives charge mode with ADC and charging
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_power_mode_controller #(
   parameter int WAKE_CYCLES = `PMC_WAKE_MS * `PMC_CLK_MHZ * 1000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // analogue comparators and pins
   input wire logic input_valid_i,
   input wire logic input_overvoltage_i,
   input wire logic battery_overcurrent_detect_i,
   input wire logic manual_reset_button_n_i,
   input wire logic low_power_select_n_i,
   input wire logic battery_inserted_i,
   input wire logic serial_busy_i,
   input wire logic interrupt_pending_i,
   input wire logic watchdog_expired_i,
   // gated functions
   output logic battery_discharge_switch_o,
   output logic clocks_on_o,
   output logic serial_enable_o,
   output logic adc_enable_o,
   output logic interrupt_enable_o,
   output logic charge_enable_gate_o,
   output logic current_limit_enable_o,
   output logic aux_output_on_o,
   output logic [1:0] mode_o
);
   // ****************************************************************
   // state
   // ****************************************************************
   pmc_pkg::pmc_mode_t mode_r, mode_nxt;
   logic ship_entry_request_r;
   logic aux_output_on_r;
   logic [11:0] battery_undervoltage_threshold_r;
   logic [11:0] battery_mv_r;
   logic battery_undervoltage_detect_r;
   logic [31:0] wake_cnt_r;
   logic wake_armed_r;
   logic ins_d_r;
   logic ack_r;
   logic [31:0] readdata_r;
   logic wr_hit, rd_hit, btn_wake;
   logic [12:0] rise_lvl;

   // a write lands only at the edge that sees waitrequest low
   assign wr_hit = avs_write_i && ack_r;
   assign rd_hit = avs_read_i && !ack_r;
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   assign avs_readdata_o = readdata_r;

   // ****************************************************************
   // bus slave, one wait state
   // ****************************************************************
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         readdata_r <= 32'h00000000;
      end else if (rd_hit) begin
         if (avs_address_i == `PMC_ADDR_CTRL) begin
            readdata_r <= {30'h0, aux_output_on_r, ship_entry_request_r};
         end else if (avs_address_i == `PMC_ADDR_STATUS) begin
            readdata_r <= {28'h0, battery_undervoltage_detect_r,
                           battery_discharge_switch_o, mode_r};
         end else if (avs_address_i == `PMC_ADDR_THRESH) begin
            readdata_r <= {20'h0, battery_undervoltage_threshold_r};
         end else if (avs_address_i == `PMC_ADDR_BATT) begin
            readdata_r <= {20'h0, battery_mv_r};
         end else begin
            readdata_r <= `PMC_UNMAPPED;
         end
      end
   end

   // ship request: cleared by host while input valid or by ship entry;
   // watchdog expiry has no effect on it
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ship_entry_request_r <= 1'b0;
      end else if (mode_r == pmc_pkg::PMC_SHIP) begin
         ship_entry_request_r <= 1'b0;
      end else if (wr_hit && avs_address_i == `PMC_ADDR_CTRL &&
                   avs_byteenable_i[0]) begin
         if (avs_writedata_i[`PMC_CTRL_SHIP]) begin
            ship_entry_request_r <= 1'b1;
         end else if (input_valid_i) begin
            ship_entry_request_r <= 1'b0;
         end
      end
   end

   // aux enable only changes by software, so it survives low power
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         aux_output_on_r <= 1'b0;
      end else if (wr_hit && avs_address_i == `PMC_ADDR_CTRL &&
                   avs_byteenable_i[0]) begin
         aux_output_on_r <= avs_writedata_i[`PMC_CTRL_AUX];
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         battery_undervoltage_threshold_r <= `PMC_THRESH_RST;
         battery_mv_r <= 12'h000;
      end else if (wr_hit && avs_byteenable_i[1:0] == 2'h3) begin
         if (avs_address_i == `PMC_ADDR_THRESH) begin
            battery_undervoltage_threshold_r <= avs_writedata_i[11:0];
         end else if (avs_address_i == `PMC_ADDR_BATT) begin
            battery_mv_r <= avs_writedata_i[11:0];
         end
      end
   end

   // ****************************************************************
   // battery undervoltage with hysteresis
   // ****************************************************************
   assign rise_lvl = {1'b0, battery_undervoltage_threshold_r} +
                     {1'b0, `PMC_HYST_MV};
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         battery_undervoltage_detect_r <= 1'b1;
      end else if ({1'b0, battery_mv_r} >= rise_lvl) begin
         battery_undervoltage_detect_r <= 1'b0;
      end else if (battery_mv_r < battery_undervoltage_threshold_r) begin
         battery_undervoltage_detect_r <= 1'b1;
      end
   end

   // ****************************************************************
   // wake press timer in ship mode
   // ****************************************************************
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wake_cnt_r <= 32'h0;
         wake_armed_r <= 1'b0;
      end else if (mode_r != pmc_pkg::PMC_SHIP ||
                   manual_reset_button_n_i) begin
         wake_cnt_r <= 32'h0;
         if (mode_r != pmc_pkg::PMC_SHIP) begin
            wake_armed_r <= 1'b0;
         end
      end else if (wake_cnt_r >= WAKE_CYCLES - 1) begin
         wake_armed_r <= 1'b1;
      end else begin
         wake_cnt_r <= wake_cnt_r + 32'h1;
      end
   end

   assign btn_wake = wake_armed_r && manual_reset_button_n_i &&
                     battery_mv_r > `PMC_THRESH_MAX;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ins_d_r <= 1'b0;
      end else begin
         ins_d_r <= battery_inserted_i;
      end
   end

   // ****************************************************************
   // mode selection
   // ****************************************************************
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         pmc_pkg::PMC_SHIP: begin
            if (input_valid_i) begin
               mode_nxt = pmc_pkg::PMC_CHARGE;
            end else if (btn_wake) begin
               mode_nxt = pmc_pkg::PMC_ACTIVE;
            end
         end
         default: begin
            // ship first, then charge, active, low power
            if ((battery_inserted_i && !ins_d_r && !input_valid_i &&
                 manual_reset_button_n_i) ||
                (ship_entry_request_r && !input_valid_i &&
                 manual_reset_button_n_i)) begin
               mode_nxt = pmc_pkg::PMC_SHIP;
            end else if (input_valid_i) begin
               mode_nxt = pmc_pkg::PMC_CHARGE;
            end else if (low_power_select_n_i || input_overvoltage_i ||
                         !manual_reset_button_n_i) begin
               mode_nxt = pmc_pkg::PMC_ACTIVE;
            end else if (mode_r == pmc_pkg::PMC_LOWPWR ||
                         (!serial_busy_i && !interrupt_pending_i)) begin
               mode_nxt = pmc_pkg::PMC_LOWPWR;
            end else begin
               mode_nxt = pmc_pkg::PMC_ACTIVE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mode_r <= pmc_pkg::PMC_ACTIVE;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // ****************************************************************
   // function gating
   // ****************************************************************
   // modes in which clocks, serial, ADC and interrupt run
   function automatic logic fn_awake(input pmc_pkg::pmc_mode_t m);
      return m == pmc_pkg::PMC_CHARGE || m == pmc_pkg::PMC_ACTIVE;
   endfunction

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         battery_discharge_switch_o <= 1'b0;
         clocks_on_o <= 1'b1;
         serial_enable_o <= 1'b0;
         adc_enable_o <= 1'b0;
         interrupt_enable_o <= 1'b0;
         charge_enable_gate_o <= 1'b0;
         current_limit_enable_o <= 1'b0;
         aux_output_on_o <= 1'b0;
         mode_o <= 2'h0;
      end else begin
         battery_discharge_switch_o <= mode_nxt != pmc_pkg::PMC_SHIP &&
            !input_valid_i && !battery_undervoltage_detect_r &&
            !battery_overcurrent_detect_i;
         clocks_on_o <= fn_awake(mode_nxt);
         serial_enable_o <= fn_awake(mode_nxt);
         adc_enable_o <= fn_awake(mode_nxt);
         interrupt_enable_o <= fn_awake(mode_nxt);
         charge_enable_gate_o <= mode_nxt == pmc_pkg::PMC_CHARGE;
         current_limit_enable_o <= mode_nxt == pmc_pkg::PMC_CHARGE;
         aux_output_on_o <= aux_output_on_r &&
            mode_nxt != pmc_pkg::PMC_SHIP;
         mode_o <= mode_nxt;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_ship_switch_off: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == pmc_pkg::PMC_SHIP |-> !battery_discharge_switch_o)
      else $error("switch on in ship mode");
   a_ship_wait_input: assert property (@(posedge clk_i) disable iff (reset_i)
      input_valid_i && mode_r != pmc_pkg::PMC_SHIP
      |=> mode_r == pmc_pkg::PMC_CHARGE)
      else $error("left charge mode while input valid");
   a_ship_wait_button: assert property (@(posedge clk_i) disable iff (reset_i)
      !manual_reset_button_n_i && mode_r != pmc_pkg::PMC_SHIP
      |=> mode_r != pmc_pkg::PMC_SHIP)
      else $error("ship entered with button low");
   a_lowpwr_serial_off: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_nxt == pmc_pkg::PMC_LOWPWR |=> !serial_enable_o && !adc_enable_o)
      else $error("serial on in low power");
   a_lowpwr_exit: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == pmc_pkg::PMC_LOWPWR && low_power_select_n_i
      |=> mode_r != pmc_pkg::PMC_LOWPWR)
      else $error("stayed in low power");
   a_active_button: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r != pmc_pkg::PMC_SHIP && !input_valid_i &&
      !manual_reset_button_n_i |=> mode_r == pmc_pkg::PMC_ACTIVE &&
      clocks_on_o)
      else $error("not active with button held");
   a_charge_gate: assert property (@(posedge clk_i) disable iff (reset_i)
      charge_enable_gate_o |-> mode_r == pmc_pkg::PMC_CHARGE)
      else $error("charge gate outside charge mode");
   a_ovp_active: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r != pmc_pkg::PMC_SHIP && !input_valid_i && input_overvoltage_i &&
      !ship_entry_request_r && !battery_inserted_i
      |=> mode_r == pmc_pkg::PMC_ACTIVE)
      else $error("overvoltage did not force active");
   a_ocp_switch: assert property (@(posedge clk_i) disable iff (reset_i)
      battery_overcurrent_detect_i |=> !battery_discharge_switch_o)
      else $error("switch on during overcurrent");
   a_wdog_keeps_req: assert property (@(posedge clk_i) disable iff (reset_i)
      ship_entry_request_r && watchdog_expired_i &&
      mode_r != pmc_pkg::PMC_SHIP &&
      !(avs_write_i && avs_address_i == `PMC_ADDR_CTRL)
      |=> ship_entry_request_r)
      else $error("ship request lost on watchdog");
   a_ship_aux_off: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == pmc_pkg::PMC_SHIP |-> !aux_output_on_o && !clocks_on_o)
      else $error("function on in ship mode");
   a_lowpwr_clocks: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == pmc_pkg::PMC_LOWPWR |-> !clocks_on_o && !serial_enable_o)
      else $error("clocks on in low power");
   a_charge_input_current_limit: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == pmc_pkg::PMC_CHARGE |->
      current_limit_enable_o && charge_enable_gate_o)
      else $error("charge gates off in charge mode");
   a_active_gates: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_nxt == pmc_pkg::PMC_ACTIVE |=> interrupt_enable_o &&
      adc_enable_o && !charge_enable_gate_o)
      else $error("wrong gates in active mode");
   a_uv_switch_off: assert property (@(posedge clk_i) disable iff (reset_i)
      battery_undervoltage_detect_r |=> !battery_discharge_switch_o)
      else $error("switch on during undervoltage");
   a_insert_ship: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r != pmc_pkg::PMC_SHIP && battery_inserted_i && !ins_d_r &&
      !input_valid_i && manual_reset_button_n_i
      |=> mode_r == pmc_pkg::PMC_SHIP)
      else $error("insertion did not enter ship");
   a_btn_wake_level: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == pmc_pkg::PMC_SHIP && !input_valid_i &&
      battery_mv_r <= `PMC_THRESH_MAX
      |=> mode_r == pmc_pkg::PMC_SHIP)
      else $error("left ship with low battery");
endmodule

// File: tb/pmc_button_model.sv
// push-button partner model for the power mode controller
`timescale 1ns/1ps
module pmc_button_model #(
   parameter int HOLD = 12
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // press commands
   input wire logic press_i,
   input wire logic hold_i,
   // button pin
   output logic manual_reset_button_n_o
);
   int cnt_r;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_r <= 0;
      end else if (press_i) begin
         cnt_r <= HOLD;
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
      end
   end
   // held low for the whole count, as a power cycle needs
   assign manual_reset_button_n_o = !(hold_i || cnt_r != 0);
endmodule

// File: tb/pmc_power_mode_controller_tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module pmc_power_mode_controller_tb;
   localparam int WAKE = 8;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0, wr = 1'b0, in_ok = 1'b0, ovp = 1'b0, ocp = 1'b0;
   logic lp_n = 1'b1, bat_in = 1'b0, busy = 1'b0, irq = 1'b0, wdog = 1'b0;
   logic press = 1'b0, hold = 1'b0, btn_n, wreq;
   logic sw, clk_on, ser, adc, inten, chg, input_current_limit, aux;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat, q;
   logic [1:0] mode;
   int n_fail = 0, compares = 0, cyc = 0;
   pmc_power_mode_controller #(.WAKE_CYCLES(WAKE)) DUT (
      .clk_i(clk_i), .reset_i(reset_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .input_valid_i(in_ok), .input_overvoltage_i(ovp),
      .battery_overcurrent_detect_i(ocp), .manual_reset_button_n_i(btn_n),
      .low_power_select_n_i(lp_n), .battery_inserted_i(bat_in),
      .serial_busy_i(busy), .interrupt_pending_i(irq),
      .watchdog_expired_i(wdog), .battery_discharge_switch_o(sw),
      .clocks_on_o(clk_on), .serial_enable_o(ser), .adc_enable_o(adc),
      .interrupt_enable_o(inten), .charge_enable_gate_o(chg),
      .current_limit_enable_o(input_current_limit), .aux_output_on_o(aux), .mode_o(mode)
   );
   pmc_button_model #(.HOLD(WAKE + 4)) partner (
      .clk_i(clk_i), .reset_i(reset_i), .press_i(press), .hold_i(hold),
      .manual_reset_button_n_o(btn_n)
   );
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // request held until the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic chk_val(input logic [31:0] g, e, input string m);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t %s got %h", $time, m, g);
      end
   endtask
   task automatic chk_mode(input pmc_pkg::pmc_mode_t e, input string m);
      chk_val({30'h0, mode}, {30'h0, 2'(e)}, m);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      wt(2);
      bus(1'b0, 4'h2, 32'h0);
      chk_val(q, 32'h00000C00, "threshold reset");
      bus(1'b0, 4'h7, 32'h0);
      chk_val(q, 32'hFFFFFFFF, "unmapped read");
      bus(1'b1, 4'h3, 32'h00000E00);
      wt(3);
      chk_mode(pmc_pkg::PMC_ACTIVE, "battery only");
      chk_val(sw, 1'b1, "switch on");
      @(posedge clk_i);
      in_ok <= 1'b1;
      wt(3);
      chk_mode(pmc_pkg::PMC_CHARGE, "charge");
      chk_val({chg, input_current_limit, ser, adc, inten}, 5'h1F, "charge gates");
      bus(1'b1, 4'h0, 32'h1);
      wt(3);
      chk_mode(pmc_pkg::PMC_CHARGE, "ship postponed");
      bus(1'b1, 4'h0, 32'h0);
      @(posedge clk_i);
      in_ok <= 1'b0;
      wt(3);
      chk_mode(pmc_pkg::PMC_ACTIVE, "ship cancelled");
      $display("test request cancel done");
      @(posedge clk_i);
      in_ok <= 1'b1;
      wt(3);
      bus(1'b1, 4'h0, 32'h1);
      @(posedge clk_i);
      wdog <= 1'b1;
      wt(3);
      @(posedge clk_i);
      in_ok <= 1'b0;
      wt(3);
      chk_mode(pmc_pkg::PMC_SHIP, "ship after watchdog");
      chk_val({sw, clk_on, ser, adc, inten, aux}, 6'h00, "ship off");
      @(posedge clk_i);
      in_ok <= 1'b1;
      wdog <= 1'b0;
      wt(3);
      chk_mode(pmc_pkg::PMC_CHARGE, "input wakes ship");
      @(posedge clk_i);
      hold <= 1'b1;
      bus(1'b1, 4'h0, 32'h1);
      @(posedge clk_i);
      in_ok <= 1'b0;
      wt(3);
      chk_mode(pmc_pkg::PMC_ACTIVE, "button low waits");
      @(posedge clk_i);
      hold <= 1'b0;
      wt(3);
      chk_mode(pmc_pkg::PMC_SHIP, "button released");
      @(posedge clk_i);
      press <= 1'b1;
      @(posedge clk_i);
      press <= 1'b0;
      wt(WAKE + 10);
      chk_mode(pmc_pkg::PMC_ACTIVE, "button wakes ship");
      $display("test ship done");
      bus(1'b1, 4'h3, 32'h00000D00);
      @(posedge clk_i);
      bat_in <= 1'b1;
      wt(3);
      chk_mode(pmc_pkg::PMC_SHIP, "insertion");
      @(posedge clk_i);
      press <= 1'b1;
      @(posedge clk_i);
      press <= 1'b0;
      wt(WAKE + 10);
      chk_mode(pmc_pkg::PMC_SHIP, "low battery no wake");
      @(posedge clk_i);
      in_ok <= 1'b1;
      wt(3);
      bus(1'b1, 4'h3, 32'h00000E00);
      bus(1'b1, 4'h0, 32'h2);
      @(posedge clk_i);
      in_ok <= 1'b0;
      lp_n <= 1'b0;
      busy <= 1'b1;
      irq <= 1'b1;
      wt(3);
      chk_mode(pmc_pkg::PMC_ACTIVE, "serial busy");
      @(posedge clk_i);
      busy <= 1'b0;
      wt(3);
      chk_mode(pmc_pkg::PMC_ACTIVE, "interrupt pending");
      @(posedge clk_i);
      irq <= 1'b0;
      wt(3);
      chk_mode(pmc_pkg::PMC_LOWPWR, "low power");
      chk_val({clk_on, ser, adc, aux}, 4'h1, "low power gates");
      @(posedge clk_i);
      hold <= 1'b1;
      wt(3);
      chk_val({mode, clk_on}, 3'h5, "button held");
      @(posedge clk_i);
      hold <= 1'b0;
      wt(3);
      chk_mode(pmc_pkg::PMC_LOWPWR, "button back");
      @(posedge clk_i);
      ovp <= 1'b1;
      wt(3);
      chk_mode(pmc_pkg::PMC_ACTIVE, "overvoltage");
      @(posedge clk_i);
      ovp <= 1'b0;
      lp_n <= 1'b1;
      wt(3);
      chk_mode(pmc_pkg::PMC_ACTIVE, "select high");
      $display("test low power done");
      bus(1'b1, 4'h3, 32'h00000BFF);
      wt(3);
      bus(1'b0, 4'h1, 32'h0);
      chk_val(q & 32'hC, 32'h8, "undervoltage");
      bus(1'b1, 4'h3, 32'h00000C95);
      wt(3);
      chk_val(sw, 1'b0, "inside hysteresis");
      bus(1'b1, 4'h3, 32'h00000C97);
      wt(3);
      chk_val(sw, 1'b1, "above hysteresis");
      bus(1'b1, 4'h2, 32'h00000D00);
      wt(3);
      chk_val(sw, 1'b0, "raised threshold");
      bus(1'b1, 4'h2, 32'h00000C00);
      wt(3);
      @(posedge clk_i);
      ocp <= 1'b1;
      wt(3);
      chk_val(sw, 1'b0, "overcurrent");
      $display("test battery done");
      end_of_test();
   end
endmodule
